// file: src/efa_pkg.sv
// Constants shared by the energy-to-frequency accumulator files.
package efa_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SAMPLE_PERIOD_NS = 400;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SCNT_W = 5;
    localparam logic [SCNT_W-1:0] SAMPLE_LAST = SCNT_W'(SAMPLE_CYCLES - 1);
    localparam int CF_PULSE_CYCLES = 16;

    // ****************************************************************
    // Widths and field positions
    // ****************************************************************
    localparam int ACC_W = 54;
    localparam int ENERGY_W = 24;
    localparam int PHASE_W = 28;
    localparam int DIV_W = 8;
    localparam int SCALE_W = 12;
    localparam int GAIN_W = 8;
    localparam int GAIN_ABS_BIT = 2;
    localparam int GAIN_NOLOAD_DIS_BIT = 3;
    localparam int SIGN_LSB = 12;
    localparam int NOLOAD_THRESHOLD = 687;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADDR_ENERGY = 8'h00;
    localparam logic [ADR_W-1:0] ADDR_ENERGY_RC = 8'h04;
    localparam logic [ADR_W-1:0] ADDR_DIVIDER = 8'h08;
    localparam logic [ADR_W-1:0] ADDR_NUMERATOR = 8'h0C;
    localparam logic [ADR_W-1:0] ADDR_DENOMINATOR = 8'h10;
    localparam logic [ADR_W-1:0] ADDR_GAIN = 8'h18;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [SCALE_W-1:0] SCALE_RST = 12'h000;

endpackage

// file: src/efa_dfc_if.sv
// Link from the energy accumulator to the output pulse scaler.
`timescale 1ns/1ns
interface efa_dfc_if;
    logic pulse;
    logic [efa_pkg::SCALE_W-1:0] num;
    logic [efa_pkg::SCALE_W-1:0] den;
    modport src (output pulse, output num, output den);
    modport sink (input pulse, input num, input den);
endinterface

// file: src/efa_pulse_scaler.sv
// Scales converter pulses by numerator over denominator into the calibration pulse.
`timescale 1ns/1ns
module efa_pulse_scaler #(
    parameter int PULSE_CYCLES = efa_pkg::CF_PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    efa_dfc_if.sink dfc,
    output logic cf_o
);
    localparam int FRAC_W = efa_pkg::SCALE_W + 2;

    typedef struct packed {
        logic [FRAC_W-1:0] frac;
        logic [7:0] wcnt;
        logic cf;
    } efa_scaler_t;

    efa_scaler_t s;
    efa_scaler_t nx;
    logic [FRAC_W-1:0] eff_num;
    logic [FRAC_W-1:0] eff_den;
    logic [FRAC_W-1:0] sum;

    always_comb begin
        nx = s;
        eff_num = (dfc.num == '0) ? FRAC_W'(1) : FRAC_W'(dfc.num);
        eff_den = (dfc.den == '0) ? FRAC_W'(1) : FRAC_W'(dfc.den);
        sum = s.frac + eff_num;
        if (s.wcnt != '0) begin
            nx.wcnt = s.wcnt - 8'h01;
        end
        if (dfc.pulse) begin
            if (sum >= eff_den) begin
                // One output pulse per den/num converter pulses.
                nx.frac = sum - eff_den;
                nx.wcnt = 8'(PULSE_CYCLES);
                if (nx.frac >= eff_den) begin
                    // A ratio above one cannot keep up; drop the excess.
                    nx.frac = '0;
                end
            end else begin
                nx.frac = sum;
            end
        end
        nx.cf = (nx.wcnt != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= nx;
        end
    end

    assign cf_o = s.cf;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    scale_nonzero_a: assert property (eff_num != '0 && eff_den != '0)
        else $error("Effective scaling value is zero.");
    cf_cause_a: assert property ($rose(s.cf) |-> $past(dfc.pulse))
        else $error("Calibration pulse without a converter pulse.");
    unity_ratio_a: assert property ((dfc.pulse && dfc.num == dfc.den && s.frac == '0) |=> s.cf)
        else $error("Unity ratio failed to pass a converter pulse.");
endmodule

// file: src/efa_top.sv
// Energy accumulator with divider, creep threshold, sum mode and pulse output.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module efa_top #(
    parameter int PW = efa_pkg::PHASE_W,
    parameter int CF_PULSE_CYCLES = efa_pkg::CF_PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [efa_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic signed [PW-1:0] power_a_i,
    input wire logic signed [PW-1:0] power_b_i,
    input wire logic signed [PW-1:0] power_c_i,
    output logic calibration_pulse_out_o
);
    localparam int ACC_W = efa_pkg::ACC_W;
    localparam int ENERGY_W = efa_pkg::ENERGY_W;
    localparam int SAMPLE_GAP = efa_pkg::SAMPLE_CYCLES;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [ENERGY_W-1:0] energy;
        logic [ENERGY_W-1:0] prev;
        logic [efa_pkg::DIV_W-1:0] div;
        logic [efa_pkg::SCALE_W-1:0] num;
        logic [efa_pkg::SCALE_W-1:0] den;
        logic [efa_pkg::GAIN_W-1:0] gain;
        logic [2:0] sign;
        logic [efa_pkg::SCNT_W-1:0] scnt;
        logic ack;
        logic [31:0] dat;
        logic dfc;
    } efa_state_t;

    efa_state_t s;
    efa_state_t nx;

    // ****************************************************************
    // Bus helpers
    // ****************************************************************
    function automatic logic [31:0] efa_merge(input logic [31:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // Per-phase power conditioning
    // ****************************************************************
    logic signed [PW-1:0] phase [3];
    logic [PW-1:0] mag [3];
    logic keep [3];
    logic [2:0] sign_now;
    logic abs_mode;

    assign phase[0] = power_a_i;
    assign phase[1] = power_b_i;
    assign phase[2] = power_c_i;
    assign abs_mode = s.gain[efa_pkg::GAIN_ABS_BIT];

    generate
        for (genvar g = 0; g < 3; g++) begin : gen_phase
            assign mag[g] = phase[g][PW-1] ? PW'(-phase[g]) : PW'(phase[g]);
            // The threshold is applied to each phase on its own magnitude.
            assign keep[g] = s.gain[efa_pkg::GAIN_NOLOAD_DIS_BIT] ||
                             (mag[g] >= PW'(efa_pkg::NOLOAD_THRESHOLD));
            // Sign is reported whatever the summation mode.
            assign sign_now[g] = phase[g][PW-1];
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic req;
    logic tick;
    logic clear;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] base;
    logic [efa_pkg::DIV_W-1:0] ediv;
    logic signed [ACC_W-1:0] quot;
    logic [31:0] wr;

    always_comb begin
        nx = s;
        req = cyc_i && stb_i && !s.ack;
        tick = (s.scnt == efa_pkg::SAMPLE_LAST);
        clear = 1'b0;
        wr = 32'h0000_0000;
        nx.scnt = tick ? '0 : s.scnt + 1'b1;
        nx.ack = req;
        nx.dfc = 1'b0;

        // Bus slave: answer every request, unmapped reads return zero.
        if (req && !we_i) begin
            if (adr_i == efa_pkg::ADDR_ENERGY) begin
                nx.dat = {8'h00, s.energy};
            end else if (adr_i == efa_pkg::ADDR_ENERGY_RC) begin
                nx.dat = {8'h00, s.energy};
                clear = 1'b1;
            end else if (adr_i == efa_pkg::ADDR_DIVIDER) begin
                nx.dat = {24'h00_0000, s.div};
            end else if (adr_i == efa_pkg::ADDR_NUMERATOR) begin
                nx.dat = {17'h0_0000, s.sign, s.num};
            end else if (adr_i == efa_pkg::ADDR_DENOMINATOR) begin
                nx.dat = {20'h0_0000, s.den};
            end else if (adr_i == efa_pkg::ADDR_GAIN) begin
                nx.dat = {24'h00_0000, s.gain};
            end else begin
                nx.dat = 32'h0000_0000;
            end
        end else if (req && we_i) begin
            nx.dat = 32'h0000_0000;
            if (adr_i == efa_pkg::ADDR_DIVIDER) begin
                wr = efa_merge({24'h00_0000, s.div}, dat_i, sel_i);
                nx.div = wr[efa_pkg::DIV_W-1:0];
            end else if (adr_i == efa_pkg::ADDR_NUMERATOR) begin
                wr = efa_merge({20'h0_0000, s.num}, dat_i, sel_i);
                nx.num = wr[efa_pkg::SCALE_W-1:0];
            end else if (adr_i == efa_pkg::ADDR_DENOMINATOR) begin
                wr = efa_merge({20'h0_0000, s.den}, dat_i, sel_i);
                nx.den = wr[efa_pkg::SCALE_W-1:0];
            end else if (adr_i == efa_pkg::ADDR_GAIN) begin
                wr = efa_merge({24'h00_0000, s.gain}, dat_i, sel_i);
                nx.gain = wr[efa_pkg::GAIN_W-1:0];
            end
        end

        // One sum feeds the energy registers and the pulse path alike.
        sum = '0;
        for (int i = 0; i < 3; i++) begin
            if (keep[i]) begin
                if (abs_mode) begin
                    sum = sum + ACC_W'(mag[i]);
                end else begin
                    sum = sum + ACC_W'(phase[i]);
                end
            end
        end

        // A sample in the clearing cycle lands on the zeroed value.
        base = clear ? '0 : s.acc;
        nx.acc = tick ? base + sum : base;
        if (tick) begin
            nx.sign = sign_now;
        end

        ediv = (nx.div == '0) ? 8'h01 : nx.div;
        quot = $signed(nx.acc) / $signed({1'b0, ediv});
        nx.energy = quot[ACC_W-1 -: ENERGY_W];

        // Any change of the readable value is one LSB step at full load.
        if (clear) begin
            nx.prev = nx.energy;
        end else begin
            nx.prev = s.energy;
            nx.dfc = (s.energy != s.prev);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.gain <= efa_pkg::GAIN_RST;
            s.div <= efa_pkg::DIV_RST;
            s.num <= efa_pkg::SCALE_RST;
            s.den <= efa_pkg::SCALE_RST;
        end else begin
            s <= nx;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = s.dat;

    // ****************************************************************
    // Output pulse scaling
    // ****************************************************************
    efa_dfc_if dfc_link();

    assign dfc_link.pulse = s.dfc;
    assign dfc_link.num = s.num;
    assign dfc_link.den = s.den;

    efa_pulse_scaler #(
        .PULSE_CYCLES(CF_PULSE_CYCLES)
    ) u_scaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dfc(dfc_link.sink),
        .cf_o(calibration_pulse_out_o)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sample_period_a: assert property (tick |=> !tick ##(SAMPLE_GAP - 1) tick)
        else $error("Sample strobe spacing wrong.");
    bus_ack_a: assert property (req |=> s.ack ##1 !s.ack)
        else $error("Bus answer timing wrong.");
    undivided_energy_a: assert property (s.div == '0 |-> s.energy == s.acc[ACC_W-1 -: ENERGY_W])
        else $error("Undivided energy is not the top bits.");
    read_clear_a: assert property ((clear && !tick) |=> s.acc == '0)
        else $error("Read-clear did not zero the accumulator.");
    plain_read_a: assert property ((req && !we_i && adr_i == efa_pkg::ADDR_ENERGY && !tick)
                                   |=> s.acc == $past(s.acc))
        else $error("Plain read changed the accumulator.");
    creep_block_a: assert property ((tick && !clear && !s.gain[efa_pkg::GAIN_NOLOAD_DIS_BIT] &&
                                     !keep[0] && !keep[1] && !keep[2]) |=> s.acc == $past(s.acc))
        else $error("Sub-threshold power was accumulated.");
    abs_rise_a: assert property ((tick && !clear && abs_mode)
                                 |=> ((s.acc - $past(s.acc)) >> (ACC_W - 1)) == '0)
        else $error("Absolute mode decreased the energy.");
    sign_flags_a: assert property (tick |=> s.sign == $past(sign_now))
        else $error("Reverse power flags not updated.");
    noload_reset_a: assert property ($past(rst_i) |-> !s.gain[efa_pkg::GAIN_NOLOAD_DIS_BIT])
        else $error("No-load threshold not enabled after reset.");
    dfc_step_a: assert property ((s.energy != s.prev && !clear) |=> s.dfc)
        else $error("Energy step without converter pulse.");
endmodule

// file: dv/efa_cal_counter.sv
// Calibration equipment model that counts calibration output pulses.
`timescale 1ns/1ns
module efa_cal_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pulse_i,
    output logic [31:0] count_o
);
    logic prev;

    // Each rising edge is one pulse, so a stretched pulse still counts once.
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
            count_o <= 32'h00000000;
        end else begin
            prev <= pulse_i;
            if (pulse_i && !prev) begin
                count_o <= count_o + 32'h00000001;
            end
        end
    end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the energy-to-frequency accumulator.
`timescale 1ns/1ns
module testbench;
    // ********************************
    // Signals and model state
    // ********************************
    localparam int PW = efa_pkg::PHASE_W;
    localparam longint THR = efa_pkg::NOLOAD_THRESHOLD;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat, q_rd, m_rd, mw, cnt;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cf, rc, tk;
    logic [3:0] sel = 4'hF;
    logic signed [PW-1:0] pa = '0, pb = '0, pc = '0;
    int error_cnt = 0, comparisons = 0, scnt, exp_cf;
    longint acc, frac, qd;
    logic [7:0] m_div, m_gain;
    logic [11:0] m_num, m_den, num_v, den_v;
    logic [2:0] m_sign;
    logic [23:0] m_en, e;
    logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

    always #(efa_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    efa_top #(.PW(PW), .CF_PULSE_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .power_a_i(pa),
        .power_b_i(pb), .power_c_i(pc), .calibration_pulse_out_o(cf));
    efa_cal_counter cal (.clk_i(clk_i), .rst_i(rst_i), .pulse_i(cf), .count_o(cnt));

    function automatic longint ph(logic signed [PW-1:0] p);
        longint v;
        v = p;
        if (!m_gain[efa_pkg::GAIN_NOLOAD_DIS_BIT] && v < THR && v > -THR) begin
            return 0;
        end
        return (m_gain[efa_pkg::GAIN_ABS_BIT] && v < 0) ? -v : v;
    endfunction

    function automatic logic [31:0] rd_exp(logic [7:0] a);
        case (a)
            efa_pkg::ADDR_ENERGY, efa_pkg::ADDR_ENERGY_RC: return {8'h00, m_en};
            efa_pkg::ADDR_DIVIDER: return {24'h000000, m_div};
            efa_pkg::ADDR_NUMERATOR: return {17'h00000, m_sign, m_num};
            efa_pkg::ADDR_DENOMINATOR: return {20'h00000, m_den};
            efa_pkg::ADDR_GAIN: return {24'h000000, m_gain};
            default: return 32'h00000000;
        endcase
    endfunction

    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] d, logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) o[8*i+:8] = d[8*i+:8];
        end
        return o;
    endfunction

    function automatic logic signed [PW-1:0] rp();
        logic signed [PW-1:0] m;
        m = {2'b01, (PW-2)'($urandom)};
        return ($urandom_range(1, 0) != 0) ? -m : m;
    endfunction

    // Reference model, stepped on the same edges as the design.
    always @(posedge clk_i) begin
        tk = cyc && stb && !ack;
        if (rst_i) begin
            acc = 0;
            frac = 0;
            scnt = 0;
            exp_cf = 0;
            {m_div, m_gain, m_num, m_den, m_sign, m_en} = '0;
        end else begin
            if (tk && !we) m_rd = rd_exp(adr);
            rc = tk && !we && adr == efa_pkg::ADDR_ENERGY_RC;
            if (tk && we) begin
                mw = mrg(rd_exp(adr), wdat, sel);
                case (adr)
                    efa_pkg::ADDR_DIVIDER: m_div = mw[7:0];
                    efa_pkg::ADDR_NUMERATOR: m_num = mw[11:0];
                    efa_pkg::ADDR_DENOMINATOR: m_den = mw[11:0];
                    efa_pkg::ADDR_GAIN: m_gain = mw[7:0];
                    default: ;
                endcase
            end
            if (rc) acc = 0;
            if (scnt == efa_pkg::SAMPLE_CYCLES - 1) begin
                acc = acc + ph(pa) + ph(pb) + ph(pc);
                m_sign = {pc < 0, pb < 0, pa < 0};
                scnt = 0;
            end else scnt++;
            qd = acc / (m_div == 8'h00 ? 64'sd1 : longint'(m_div));
            e = qd[53:30];
            if (e !== m_en && !rc) begin
                frac = frac + (m_num == 12'h000 ? 1 : m_num);
                if (frac >= (m_den == 12'h000 ? 1 : m_den)) begin
                    frac = frac - (m_den == 12'h000 ? 1 : m_den);
                    exp_cf++;
                end
            end
            m_en = e;
        end
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cf(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: pulse count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("Error at %0t: no bus answer", $time);
        end
        q_rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h00000000, 4'hF);
        chk_rd(q_rd, m_rd);
    endtask

    task automatic wait_smp(input int n);
        repeat (n) begin
            @(negedge clk_i);
            while (scnt != efa_pkg::SAMPLE_CYCLES - 1) @(negedge clk_i);
            @(posedge clk_i);
        end
    endtask

    task automatic setp(input logic signed [PW-1:0] a, input logic signed [PW-1:0] b, input logic signed [PW-1:0] c);
        pa <= a;
        pb <= b;
        pc <= c;
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        void'($urandom(69491));
        do_reset();
        foreach (addrs[i]) rd(addrs[i]);
        foreach (addrs[i]) wb(1'b1, addrs[i], 32'hFFFFFFFF, 4'hF);
        wb(1'b1, efa_pkg::ADDR_NUMERATOR, 32'h00000A5C, 4'h2);
        foreach (addrs[i]) rd(addrs[i]);
        $display("test registers done");
        for (int it = 0; it < 3; it++) begin
            do_reset();
            den_v = 12'($urandom_range(4095, 1));
            num_v = 12'($urandom_range(den_v, 0));
            wb(1'b1, efa_pkg::ADDR_GAIN, it == 1 ? 32'h00000004 : 32'h00000000, 4'hF);
            wb(1'b1, efa_pkg::ADDR_DIVIDER, it == 2 ? 32'h00000003 : 32'h00000000, 4'hF);
            wb(1'b1, efa_pkg::ADDR_NUMERATOR, it == 0 ? {20'h00000, num_v} : 32'h00000000, 4'hF);
            wb(1'b1, efa_pkg::ADDR_DENOMINATOR, it == 0 ? {20'h00000, den_v} : 32'h00000000, 4'hF);
            wait_smp(1);
            setp(rp(), rp(), rp());
            wait_smp(60);
            rd(efa_pkg::ADDR_NUMERATOR);
            setp('0, '0, '0);
            wait_smp(2);
            rd(efa_pkg::ADDR_ENERGY);
            rd(efa_pkg::ADDR_ENERGY);
            rd(efa_pkg::ADDR_ENERGY_RC);
            rd(efa_pkg::ADDR_ENERGY);
            repeat (10) @(posedge clk_i);
            chk_cf(cnt, 32'(exp_cf));
            $display("test energy mode %0d done", it);
        end
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wb(1'b1, efa_pkg::ADDR_GAIN, k != 0 ? 32'h00000008 : 32'h00000000, 4'hF);
            wait_smp(1);
            setp(28'sh4000000, 28'sh4000000, -28'sh00003E8);
            wait_smp(8);
            setp(28'sh00002AF, 28'sh00002AE, -28'sh00002AF);
            wait_smp(16);
            setp('0, '0, '0);
            wait_smp(2);
            rd(efa_pkg::ADDR_ENERGY);
            chk_rd(q_rd, k != 0 ? 32'h00000001 : 32'h00000000);
            $display("test no-load %0d done", k);
        end
        complete_run();
    end
endmodule
